// >>> crf_regs.sv
// Overview of operation
// RL1: One 8-bit accumulator feeds operations and takes their results.
// RL2: 16-bit index register is high byte joined to low byte.
// RL3: Reset sets the stack pointer to 00FF.
// RL4: Stack low-byte reload sets low byte to FF, keeps high byte.
// RL5: Stack pointer names next free byte; push decrements, pull increments.
// RL6: Program counter steps on each fetch; jumps and interrupts load a target.
// RL7: Reset loads program counter from the top two bytes, high byte first.
// RL8: Flag register bits 6 and 5 always read one.
// RL9: Overflow flag shows two's complement overflow.
// RL10: Half-carry flag shows carry from bit 3 into 4 on adds.
// RL11: Mask set blocks maskable interrupts; set after stacking, before vector.
// RL12: Interrupt entry does not stack the index high byte.
// RL13: On mask clear the highest-priority pending request goes first.
// RL14: Interrupt return pulls saved registers including the saved mask.
// RL15: Reset sets the mask; mask clear instruction clears it.
// RL16: Negative flag copies result bit 7.
// RL17: Zero flag set on an all-zero result, else cleared.
// RL18: Carry set on add carry-out or subtract borrow; bit test and shifts too.
// RL19: Wait clears mask and sleeps; interrupt exit keeps it clear.
// RL20: Stop clears mask and sleeps; restart waits the stabilisation delay.
// RL21: Break loads trap opcode and break or monitor vector.
// RL22: Break starts at instruction end; return ends it only if request dropped. Here break starts whenever the sequencer is idle; break_last_cycle is unused.
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
module crf_regs
    import crf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [IRQ_COUNT-1:0] irq_req,
    input wire logic break_req,
    input wire logic break_last_cycle,
    input wire logic monitor_mode,
    output logic [15:0] vector_addr,
    output logic vector_read,
    input wire logic [7:0] vector_data,
    output logic [7:0] instr_reg,
    output logic cpu_clock_run
);

    typedef enum logic [3:0] {
        ST_RST_HI,
        ST_RST_LO,
        ST_IDLE,
        ST_PUSH,
        ST_VEC_HI,
        ST_VEC_LO,
        ST_PULL,
        ST_SLEEP,
        ST_STAB
    } crf_state_e;

    crf_state_e state_q, state_d;
    logic [7:0] acc_q, acc_d;
    logic [7:0] idx_hi_q, idx_hi_d;
    logic [7:0] idx_lo_q, idx_lo_d;
    logic [15:0] sp_q, sp_d;
    logic [15:0] pc_q, pc_d;
    logic [7:0] flags_q, flags_d;
    logic [2:0] step_q, step_d;
    logic [15:0] vaddr_q, vaddr_d;
    logic [7:0] instr_q, instr_d;
    logic brk_active_q, brk_active_d;
    logic stopped_q, stopped_d;
    logic [11:0] stab_q, stab_d;
    logic [31:0] rdata_q, rdata_d;
    logic rd_ack_q, rd_ack_d;
    logic [7:0] stack_mem [0:255];
    logic stk_we;
    logic [7:0] stk_wdata;
    logic [7:0] stk_rdata;

    // Operation decode of a command write
    logic cmd_go;
    logic [4:0] op;
    logic [7:0] opnd;
    logic [2:0] bitsel;
    logic [8:0] sum;
    logic [4:0] half;
    logic [7:0] res;
    logic [7:0] corr;
    logic irq_any;
    logic [15:0] irq_vec;
    logic take_brk;
    logic bus_busy;

    assign op = avs_writedata[CMD_OP_LSB +: CMD_OP_W];
    assign opnd = avs_writedata[CMD_DATA_LSB +: 8];
    assign bitsel = avs_writedata[CMD_BIT_LSB +: 3];
    assign stk_rdata = stack_mem[sp_q[7:0] + 8'h01];

    // Lowest index is the highest priority request
    always_comb begin
        irq_any = |irq_req;
        irq_vec = VEC_IRQ_BASE;
        for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
            if (irq_req[i]) begin
                irq_vec = VEC_IRQ_BASE - 16'(2 * i); // RL13
            end
        end
    end

    // Break begins whenever the sequencer is idle; break_last_cycle is not used
    assign take_brk = break_req && !brk_active_q && (state_q == ST_IDLE); // RL22
    assign bus_busy = (state_q != ST_IDLE) || take_brk
        || (irq_any && !flags_q[FLAG_I]);
    assign cmd_go = avs_write && !bus_busy && (avs_address == ADDR_COMMAND);

    // Bus answers: reads take one wait cycle, writes stall while sequencing
    assign avs_waitrequest = (avs_read && !rd_ack_q) || (avs_write && bus_busy);
    assign avs_readdata = rdata_q;
    assign vector_addr = vaddr_q;
    assign vector_read = (state_q == ST_RST_HI) || (state_q == ST_RST_LO)
        || (state_q == ST_VEC_HI) || (state_q == ST_VEC_LO);
    assign instr_reg = instr_q;
    assign cpu_clock_run = (state_q != ST_SLEEP) && (state_q != ST_STAB);

    // Next state of the register set and its sequencer
    always_comb begin
        state_d = state_q;
        acc_d = acc_q;
        idx_hi_d = idx_hi_q;
        idx_lo_d = idx_lo_q;
        sp_d = sp_q;
        pc_d = pc_q;
        flags_d = flags_q;
        step_d = step_q;
        vaddr_d = vaddr_q;
        instr_d = instr_q;
        brk_active_d = brk_active_q;
        stopped_d = stopped_q;
        stab_d = stab_q;
        stk_we = 1'b0;
        stk_wdata = 8'h00;
        sum = 9'h000;
        half = 5'h00;
        res = 8'h00;
        corr = 8'h00;
        case (state_q)
            ST_RST_HI: begin
                pc_d[15:8] = vector_data; // RL7
                vaddr_d = VEC_RESET_HI + 16'h0001;
                state_d = ST_RST_LO;
            end
            ST_RST_LO: begin
                pc_d[7:0] = vector_data; // RL7
                state_d = ST_IDLE;
            end
            ST_IDLE: begin
                if (take_brk) begin
                    instr_d = SOFTWARE_TRAP_OPCODE; // RL21
                    brk_active_d = 1'b1;
                    vaddr_d = monitor_mode ? VEC_BREAK_MONITOR : VEC_BREAK; // RL21
                    step_d = 3'h0;
                    state_d = ST_PUSH;
                end else if (irq_any && !flags_q[FLAG_I]) begin
                    vaddr_d = irq_vec; // RL11 RL13
                    step_d = 3'h0;
                    state_d = ST_PUSH;
                end else if (cmd_go) begin
                    case (op)
                        OP_ADD, OP_ADC, OP_SUB: begin
                            if (op == OP_SUB) begin
                                sum = {1'b0, acc_q} - {1'b0, opnd};
                                flags_d[FLAG_V] = (acc_q[7] != opnd[7]) && (sum[7] != acc_q[7]);
                            end else begin
                                sum = {1'b0, acc_q} + {1'b0, opnd}
                                    + {8'h00, (op == OP_ADC) && flags_q[FLAG_C]};
                                half = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]}
                                    + {4'h0, (op == OP_ADC) && flags_q[FLAG_C]};
                                flags_d[FLAG_H] = half[4]; // RL10
                                flags_d[FLAG_V] = (acc_q[7] == opnd[7])
                                    && (sum[7] != acc_q[7]); // RL9
                            end
                            res = sum[7:0];
                            flags_d[FLAG_C] = sum[8]; // RL18
                        end
                        OP_AND: begin
                            res = acc_q & opnd;
                            flags_d[FLAG_V] = 1'b0; // RL9
                        end
                        OP_ASL, OP_ROL: begin
                            res = {acc_q[6:0], (op == OP_ROL) && flags_q[FLAG_C]};
                            flags_d[FLAG_C] = acc_q[7]; // RL18
                            flags_d[FLAG_V] = acc_q[7] ^ acc_q[6]; // RL9
                        end
                        OP_LOAD: begin
                            res = opnd;
                            flags_d[FLAG_V] = 1'b0;
                        end
                        OP_DECIMAL_ADJUST: begin
                            // Correction picked from half-carry and carry
                            if (flags_q[FLAG_C] || (acc_q > 8'h99)) begin
                                corr[7:4] = 4'h6;
                                flags_d[FLAG_C] = 1'b1; // RL10 RL18
                            end
                            if (flags_q[FLAG_H] || (acc_q[3:0] > 4'h9)) begin
                                corr[3:0] = 4'h6; // RL10
                            end
                            res = acc_q + corr;
                        end
                        default: begin
                            res = acc_q;
                        end
                    endcase
                    case (op)
                        OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_ASL, OP_ROL, OP_LOAD,
                        OP_DECIMAL_ADJUST: begin
                            acc_d = res; // RL1
                            flags_d[FLAG_N] = res[7]; // RL16
                            flags_d[FLAG_Z] = (res == 8'h00); // RL17
                        end
                        OP_BIT_TEST: flags_d[FLAG_C] = opnd[bitsel]; // RL18
                        OP_STACK_LOW_RELOAD: sp_d[7:0] = SP_LOW_RELOAD; // RL4
                        OP_MASK_CLEAR: flags_d[FLAG_I] = 1'b0; // RL15
                        OP_PUSH_ACC, OP_PUSH_INDEX_HIGH: begin
                            stk_we = 1'b1;
                            stk_wdata = (op == OP_PUSH_ACC) ? acc_q : idx_hi_q;
                            sp_d = sp_q - 16'h0001; // RL5
                        end
                        OP_PULL_ACC, OP_PULL_INDEX_HIGH: begin
                            if (op == OP_PULL_ACC) begin
                                acc_d = stk_rdata;
                            end else begin
                                idx_hi_d = stk_rdata;
                            end
                            sp_d = sp_q + 16'h0001; // RL5
                        end
                        OP_SOFTWARE_TRAP: begin
                            vaddr_d = VEC_SOFTWARE;
                            step_d = 3'h0;
                            state_d = ST_PUSH;
                        end
                        OP_INTERRUPT_RETURN: begin
                            step_d = 3'h0;
                            state_d = ST_PULL;
                        end
                        OP_WAIT, OP_STOP: begin
                            flags_d[FLAG_I] = 1'b0; // RL19 RL20
                            stopped_d = (op == OP_STOP);
                            state_d = ST_SLEEP;
                        end
                        OP_JUMP: pc_d = avs_writedata[CMD_DATA_LSB +: 16]; // RL6
                        OP_FETCH: pc_d = pc_q + 16'h0001; // RL6
                        default: ;
                    endcase
                end
            end
            ST_PUSH: begin
                // Frame order: PC low, PC high, index low, accumulator, flags
                stk_we = 1'b1;
                case (step_q)
                    3'h0: stk_wdata = pc_q[7:0];
                    3'h1: stk_wdata = pc_q[15:8];
                    3'h2: stk_wdata = idx_lo_q; // RL12
                    3'h3: stk_wdata = acc_q;
                    default: stk_wdata = flags_q;
                endcase
                sp_d = sp_q - 16'h0001; // RL5
                step_d = step_q + 3'h1;
                if (step_q == STACK_FRAME_LAST) begin
                    flags_d[FLAG_I] = 1'b1; // RL11
                    state_d = ST_VEC_HI;
                end
            end
            ST_VEC_HI: begin
                pc_d[15:8] = vector_data; // RL6
                vaddr_d = vaddr_q + 16'h0001;
                state_d = ST_VEC_LO;
            end
            ST_VEC_LO: begin
                pc_d[7:0] = vector_data; // RL6
                state_d = ST_IDLE;
            end
            ST_PULL: begin
                case (step_q)
                    3'h0: flags_d = stk_rdata | FLAGS_FIXED_ONES; // RL14 RL8
                    3'h1: acc_d = stk_rdata;
                    3'h2: idx_lo_d = stk_rdata;
                    3'h3: pc_d[15:8] = stk_rdata;
                    default: pc_d[7:0] = stk_rdata;
                endcase
                sp_d = sp_q + 16'h0001; // RL5
                step_d = step_q + 3'h1;
                if (step_q == STACK_FRAME_LAST) begin
                    if (!break_req) begin
                        brk_active_d = 1'b0; // RL22
                    end
                    state_d = ST_IDLE;
                end
            end
            ST_SLEEP: begin
                // Stop wakes only on the external request, wait on any
                if (stopped_q ? irq_req[0] : irq_any) begin
                    stab_d = 12'h000;
                    state_d = stopped_q ? ST_STAB : ST_IDLE; // RL19
                end
            end
            ST_STAB: begin
                stab_d = stab_q + 12'h001;
                if (stab_q == STAB_LAST) begin
                    state_d = ST_IDLE; // RL20
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // Direct register writes only land while the sequencer is idle
        if (avs_write && !bus_busy) begin
            case (avs_address)
                ADDR_ACCUMULATOR: acc_d = avs_writedata[7:0];
                ADDR_INDEX_PAIR: begin
                    idx_hi_d = avs_writedata[15:8]; // RL2
                    idx_lo_d = avs_writedata[7:0];
                end
                ADDR_STACK_POINTER: sp_d = avs_writedata[15:0];
                ADDR_PROGRAM_COUNTER: pc_d = avs_writedata[15:0];
                ADDR_CONDITION_FLAGS: flags_d = avs_writedata[7:0] | FLAGS_FIXED_ONES; // RL8
                default: ;
            endcase
        end
    end

    // Read data capture; unmapped words read zero
    always_comb begin
        rd_ack_d = avs_read && !rd_ack_q;
        rdata_d = 32'h0000_0000;
        case (avs_address)
            ADDR_ACCUMULATOR: rdata_d[7:0] = acc_q;
            ADDR_INDEX_PAIR: rdata_d[15:0] = {idx_hi_q, idx_lo_q}; // RL2
            ADDR_STACK_POINTER: rdata_d[15:0] = sp_q;
            ADDR_PROGRAM_COUNTER: rdata_d[15:0] = pc_q;
            ADDR_CONDITION_FLAGS: rdata_d[7:0] = flags_q | FLAGS_FIXED_ONES; // RL8
            ADDR_STATUS: rdata_d = {16'h0000, instr_q, 2'b00, stopped_q, brk_active_q,
                state_q};
            default: ;
        endcase
    end

    // Register stage; reset leaves mask set and stack at top of page zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ST_RST_HI;
            acc_q <= 8'h00;
            idx_hi_q <= 8'h00;
            idx_lo_q <= 8'h00;
            sp_q <= SP_RESET; // RL3
            pc_q <= 16'h0000;
            flags_q <= FLAGS_RESET; // RL15
            step_q <= 3'h0;
            vaddr_q <= VEC_RESET_HI; // RL7
            instr_q <= 8'h00;
            brk_active_q <= 1'b0;
            stopped_q <= 1'b0;
            stab_q <= 12'h000;
            rdata_q <= 32'h0000_0000;
            rd_ack_q <= 1'b0;
        end else begin
            state_q <= state_d;
            acc_q <= acc_d;
            idx_hi_q <= idx_hi_d;
            idx_lo_q <= idx_lo_d;
            sp_q <= sp_d;
            pc_q <= pc_d;
            flags_q <= flags_d;
            step_q <= step_d;
            vaddr_q <= vaddr_d;
            instr_q <= instr_d;
            brk_active_q <= brk_active_d;
            stopped_q <= stopped_d;
            stab_q <= stab_d;
            rdata_q <= rdata_d;
            rd_ack_q <= rd_ack_d;
        end
    end

    // Stack memory indexed by the low byte of the pointer
    always_ff @(posedge clk_sys) begin
        if (stk_we) begin
            stack_mem[sp_q[7:0]] <= stk_wdata; // RL5
        end
    end

endmodule

// >>> crf_pkg.sv
package crf_pkg;

    // Register word offsets (byte addresses)
    localparam logic [4:0] ADDR_ACCUMULATOR = 5'h00;
    localparam logic [4:0] ADDR_INDEX_PAIR = 5'h04;
    localparam logic [4:0] ADDR_STACK_POINTER = 5'h08;
    localparam logic [4:0] ADDR_PROGRAM_COUNTER = 5'h0C;
    localparam logic [4:0] ADDR_CONDITION_FLAGS = 5'h10;
    localparam logic [4:0] ADDR_COMMAND = 5'h14;
    localparam logic [4:0] ADDR_STATUS = 5'h18;

    // Condition flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_I = 3;
    localparam int FLAG_H = 4;
    localparam int FLAG_V = 7;
    localparam logic [7:0] FLAGS_FIXED_ONES = 8'h60;
    localparam logic [7:0] FLAGS_RESET = 8'h68;

    // Reset values
    localparam logic [15:0] SP_RESET = 16'h00FF;
    localparam logic [7:0] SP_LOW_RELOAD = 8'hFF;

    // Vector addresses
    localparam logic [15:0] VEC_RESET_HI = 16'hFFFE;
    localparam logic [15:0] VEC_BREAK = 16'hFFFC;
    localparam logic [15:0] VEC_BREAK_MONITOR = 16'hFEFC;
    localparam logic [15:0] VEC_SOFTWARE = 16'hFFFC;
    localparam logic [15:0] VEC_IRQ_BASE = 16'hFFFA;
    localparam int IRQ_COUNT = 4;

    // Opcode placed in the instruction register on break entry
    localparam logic [7:0] SOFTWARE_TRAP_OPCODE = 8'h83;

    // Command field layout
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_W = 5;
    localparam int CMD_DATA_LSB = 8;
    localparam int CMD_BIT_LSB = 24;

    // Operation codes written to the command register
    localparam logic [4:0] OP_NOP = 5'h00;
    localparam logic [4:0] OP_ADD = 5'h01;
    localparam logic [4:0] OP_ADC = 5'h02;
    localparam logic [4:0] OP_SUB = 5'h03;
    localparam logic [4:0] OP_AND = 5'h04;
    localparam logic [4:0] OP_ASL = 5'h05;
    localparam logic [4:0] OP_ROL = 5'h06;
    localparam logic [4:0] OP_LOAD = 5'h07;
    localparam logic [4:0] OP_BIT_TEST = 5'h08;
    localparam logic [4:0] OP_DECIMAL_ADJUST = 5'h09;
    localparam logic [4:0] OP_STACK_LOW_RELOAD = 5'h0A;
    localparam logic [4:0] OP_MASK_CLEAR = 5'h0B;
    localparam logic [4:0] OP_PUSH_ACC = 5'h0C;
    localparam logic [4:0] OP_PULL_ACC = 5'h0D;
    localparam logic [4:0] OP_PUSH_INDEX_HIGH = 5'h0E;
    localparam logic [4:0] OP_PULL_INDEX_HIGH = 5'h0F;
    localparam logic [4:0] OP_SOFTWARE_TRAP = 5'h10;
    localparam logic [4:0] OP_INTERRUPT_RETURN = 5'h11;
    localparam logic [4:0] OP_WAIT = 5'h12;
    localparam logic [4:0] OP_STOP = 5'h13;
    localparam logic [4:0] OP_JUMP = 5'h14;
    localparam logic [4:0] OP_FETCH = 5'h15;

    // Oscillator stabilisation delay after stop
    localparam int CLK_MHZ = 125;
    localparam int STAB_TIME_NS = 32000;
    localparam int STAB_CYCLES = (STAB_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [11:0] STAB_LAST = 12'(STAB_CYCLES - 1);

    // Step index of the last of the five bytes stacked on interrupt entry
    localparam logic [2:0] STACK_FRAME_LAST = 3'h4;

endpackage

// >>> crf_regs_asserts.sv
`timescale 1ns/1ns
module crf_regs_chk
    import crf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic monitor_mode,
    input wire logic [15:0] vector_addr,
    input wire logic vector_read,
    input wire logic [7:0] instr_reg
);
    // One clock domain, so clocking and reset are shared
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Reads answer exactly one cycle after the request rises
    property p_rd_lat;
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read latency wrong");

    // Reset release starts at the high byte of the reset vector
    property p_rst_vec;
        $fell(rst) |-> ##[0:1] (vector_read && vector_addr == VEC_RESET_HI);
    endproperty
    a_rst_vec: assert property (p_rst_vec) else $error("reset vector not fetched");

    // High byte first, low byte on the next cycle
    property p_vec_order;
        !rst && vector_read && !vector_addr[0]
            |=> vector_read && vector_addr == $past(vector_addr) + 16'h1;
    endproperty
    a_vec_order: assert property (p_vec_order) else $error("vector byte order wrong");

    // Fixed ones survive any write
    property p_flag_ones;
        avs_read && !avs_waitrequest && avs_address == ADDR_CONDITION_FLAGS
            |-> avs_readdata[6:5] == 2'h3;
    endproperty
    a_flag_ones: assert property (p_flag_ones) else $error("flag bits 6:5 not one");

    // Unmapped reads above the status register return zero
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address > ADDR_STATUS |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    // Software cannot disturb state during a vector fetch
    property p_wr_stall;
        avs_write && vector_read |-> avs_waitrequest;
    endproperty
    a_wr_stall: assert property (p_wr_stall) else $error("write accepted in fetch");

    // Alternate break vector only in monitor mode
    property p_mon_vec;
        vector_read && vector_addr == VEC_BREAK_MONITOR |-> monitor_mode;
    endproperty
    a_mon_vec: assert property (p_mon_vec) else $error("monitor vector misused");

    // Monitor-mode break entry leaves the trap opcode in the instruction register
    property p_trap_op;
        $fell(vector_read) && $past(vector_addr) == VEC_BREAK_MONITOR + 16'h1
            |-> instr_reg == SOFTWARE_TRAP_OPCODE;
    endproperty
    a_trap_op: assert property (p_trap_op) else $error("trap opcode missing");
endmodule

bind crf_regs crf_regs_chk chk_u (.*);

// >>> tb_cpu_register_set_and_flags.sv
`timescale 1ns/1ns
module tb_cpu_register_set_and_flags
    import crf_pkg::*;
();
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] irq_req = 4'h0;
    logic break_req = 1'b0;
    logic break_last_cycle = 1'b0;
    logic monitor_mode = 1'b0;
    logic [15:0] vector_addr;
    logic vector_read;
    logic [7:0] vector_data;
    logic [7:0] instr_reg;
    logic cpu_clock_run;
    logic [31:0] q;
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    int n;

    always #4 clk_sys = ~clk_sys;
    // Distinct byte per vector address
    assign vector_data = vector_addr[7:0] ^ {vector_addr[11:8], 4'h0};

    crf_regs dut_u (.*);

    task automatic final_report();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard, well past the stop delay
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask

    // Request held until waitrequest sampled low; an idle edge follows
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask

    task automatic op(input logic [4:0] o, input logic [15:0] d);
        bus(1'b1, ADDR_COMMAND, {8'h00, d, 3'h0, o});
    endtask

    // Vector fetch marks the end of an entry sequence
    task automatic wait_vec();
        while (vector_read !== 1'b1) @(posedge clk_sys);
        while (vector_read !== 1'b0) @(posedge clk_sys);
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd("pc_rst", ADDR_PROGRAM_COUNTER, 32'hE0F);
        rd("sp_rst", ADDR_STACK_POINTER, 32'hFF);
        rd("fl_rst", ADDR_CONDITION_FLAGS, 32'h68);
        bus(1'b1, ADDR_CONDITION_FLAGS, 32'h0);
        rd("fl_ones", ADDR_CONDITION_FLAGS, 32'h60);
        bus(1'b1, ADDR_ACCUMULATOR, 32'h78);
        op(OP_ADD, 16'h8);
        rd("acc_add", ADDR_ACCUMULATOR, 32'h80);
        rd("fl_vhn", ADDR_CONDITION_FLAGS, 32'hF4);
        op(OP_ADD, 16'h80);
        rd("fl_vzc", ADDR_CONDITION_FLAGS, 32'hE3);
        bus(1'b1, ADDR_ACCUMULATOR, 32'h5A);
        op(OP_PUSH_ACC, 16'h0);
        rd("sp_push", ADDR_STACK_POINTER, 32'hFE);
        bus(1'b1, ADDR_ACCUMULATOR, 32'h0);
        op(OP_PULL_ACC, 16'h0);
        rd("acc_pull", ADDR_ACCUMULATOR, 32'h5A);
        rd("sp_pull", ADDR_STACK_POINTER, 32'hFF);
        bus(1'b1, ADDR_STACK_POINTER, 32'h1234);
        op(OP_STACK_LOW_RELOAD, 16'h0);
        rd("sp_rld", ADDR_STACK_POINTER, 32'h12FF);
        bus(1'b1, ADDR_STACK_POINTER, 32'hFF);
        bus(1'b1, ADDR_INDEX_PAIR, 32'hABCD);
        rd("index", ADDR_INDEX_PAIR, 32'hABCD);
        op(OP_FETCH, 16'h0);
        rd("pc_step", ADDR_PROGRAM_COUNTER, 32'hE10);
        op(OP_JUMP, 16'h2345);
        rd("pc_jump", ADDR_PROGRAM_COUNTER, 32'h2345);
        // Two requests pending at once, then return
        bus(1'b1, ADDR_CONDITION_FLAGS, 32'h60);
        bus(1'b1, ADDR_ACCUMULATOR, 32'h55);
        irq_req <= 4'h6;
        wait_vec();
        irq_req <= 4'h0;
        rd("pc_irq", ADDR_PROGRAM_COUNTER, 32'h809);
        rd("fl_irq", ADDR_CONDITION_FLAGS, 32'h68);
        rd("sp_irq", ADDR_STACK_POINTER, 32'hFA);
        bus(1'b1, ADDR_INDEX_PAIR, 32'h0);
        bus(1'b1, ADDR_ACCUMULATOR, 32'h0);
        op(OP_INTERRUPT_RETURN, 16'h0);
        op(OP_NOP, 16'h0);
        rd("acc_rti", ADDR_ACCUMULATOR, 32'h55);
        rd("ix_rti", ADDR_INDEX_PAIR, 32'hCD);
        rd("fl_rti", ADDR_CONDITION_FLAGS, 32'h60);
        rd("pc_rti", ADDR_PROGRAM_COUNTER, 32'h2345);
        // Wait entered with mask set, left by a request
        bus(1'b1, ADDR_CONDITION_FLAGS, 32'h68);
        op(OP_WAIT, 16'h0);
        chk("run_wait", cpu_clock_run, 1'b0);
        rd("fl_wait", ADDR_CONDITION_FLAGS, 32'h60);
        irq_req <= 4'h4;
        wait_vec();
        irq_req <= 4'h0;
        rd("pc_wait", ADDR_PROGRAM_COUNTER, 32'h607);
        op(OP_INTERRUPT_RETURN, 16'h0);
        op(OP_NOP, 16'h0);
        rd("fl_wret", ADDR_CONDITION_FLAGS, 32'h60);
        // Stop, then count the stabilisation delay after wake
        op(OP_STOP, 16'h0);
        chk("run_stop", cpu_clock_run, 1'b0);
        irq_req <= 4'h1;
        n = 0;
        @(posedge clk_sys);
        while (cpu_clock_run !== 1'b1) begin
            n++;
            @(posedge clk_sys);
        end
        chk("stab", n >= STAB_CYCLES - 2 && n <= STAB_CYCLES + 2, 1'b1);
        wait_vec();
        irq_req <= 4'h0;
        rd("pc_stop", ADDR_PROGRAM_COUNTER, 32'hA0B);
        // Break in normal and monitor mode
        for (int m = 0; m < 2; m++) begin
            monitor_mode <= m[0];
            break_req <= 1'b1;
            wait_vec();
            chk("trap", instr_reg, SOFTWARE_TRAP_OPCODE);
            rd("pc_brk", ADDR_PROGRAM_COUNTER, m[0] ? 32'h1C1D : 32'hC0D);
            break_req <= 1'b0;
            op(OP_INTERRUPT_RETURN, 16'h0);
            op(OP_NOP, 16'h0);
            bus(1'b0, ADDR_STATUS, 32'h0);
            chk("brk_end", q[4], 1'b0);
        end
        op(OP_MASK_CLEAR, 16'h0);
        rd("fl_cli", ADDR_CONDITION_FLAGS, 32'h60);
        op(OP_LOAD, 16'h19);
        op(OP_ADC, 16'h28);
        op(OP_DECIMAL_ADJUST, 16'h0);
        rd("acc_daa", ADDR_ACCUMULATOR, 32'h47);
        op(OP_SUB, 16'hC0);
        rd("fl_sub", ADDR_CONDITION_FLAGS, 32'hF5);
        op(OP_BIT_TEST, 16'h0);
        op(OP_ROL, 16'h0);
        op(OP_ASL, 16'h0);
        rd("acc_sh", ADDR_ACCUMULATOR, 32'h1C);
        op(OP_LOAD, 16'hF0);
        op(OP_AND, 16'h0F);
        rd("fl_and", ADDR_CONDITION_FLAGS, 32'h72);
        op(OP_SOFTWARE_TRAP, 16'h0);
        bus(1'b1, ADDR_INDEX_PAIR, 32'h3300);
        op(OP_PUSH_INDEX_HIGH, 16'h0);
        bus(1'b1, ADDR_INDEX_PAIR, 32'h0);
        op(OP_PULL_INDEX_HIGH, 16'h0);
        rd("ix_hi", ADDR_INDEX_PAIR, 32'h3300);
        rd("pc_trap", ADDR_PROGRAM_COUNTER, 32'hC0D);
        bus(1'b1, 5'h1C, 32'hFF);
        rd("unmap", 5'h1C, 32'h0);
        final_report();
    end
endmodule
